// ==== common/cipher_pkg.sv ====
// constants, access carrier and state record of the cipher engine
// assumes a byte-wide sram style access port driven by the spi front end
package cipher_pkg;

    // ==========================================================
    // address window
    localparam logic [7:0] ADDR_STATUS = 8'h82;
    localparam logic [7:0] ADDR_CTRL   = 8'h83;
    localparam logic [7:0] ADDR_BLK_LO = 8'h84;
    localparam logic [7:0] ADDR_BLK_HI = 8'h93;
    localparam logic [7:0] ADDR_ALIAS  = 8'h94;

    // ==========================================================
    // control and status byte layout
    localparam int CTRL_REQ_BIT  = 7;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_DIR_BIT  = 3;
    localparam int STATUS_DONE_BIT = 0;

    localparam logic [2:0] MODE_ECB = 3'h0;
    localparam logic [2:0] MODE_KEY = 3'h1;
    localparam logic [2:0] MODE_CBC = 3'h2;
    localparam logic       DIR_ENC  = 1'h0;

    // ==========================================================
    // reset values and cipher constants
    localparam logic [127:0] BLOCK_RST = 128'h0;
    localparam logic [7:0]   RCON_FIRST = 8'h01;
    localparam logic [7:0]   RCON_LAST  = 8'h36;
    localparam logic [3:0]   ROUND_FIRST = 4'h1;
    localparam logic [3:0]   ROUND_END   = 4'hB;

    // ==========================================================
    // timing
    localparam int OP_TIME_NS    = 24000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_CYCLES_I   = OP_TIME_NS / CLK_PERIOD_NS;
    localparam logic [11:0] OP_CYCLES = 12'(OP_CYCLES_I);

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sram_req_t;

    typedef struct packed {
        logic         req;
        logic [2:0]   mode;
        logic         dir;
        logic         busy;
        logic         dec;
        logic         done;
        logic [3:0]   round;
        logic [11:0]  cnt;
        logic [7:0]   rcon;
        logic [127:0] data;
        logic [127:0] ikey;
        logic [127:0] lrk;
        logic [127:0] st;
        logic [127:0] rk;
        logic [127:0] prev;
        logic         ack;
        logic [7:0]   rdata;
    } engine_state_t;

endpackage

// ==== core/cipher_engine.sv ====
// aes-128 engine behind a byte sram window, ecb both ways and cbc encrypt
// assumes accesses arrive as single-cycle strobes synchronous to clk
//
// Contract
// RULE1: only sram reads and writes within 0x82..0x94 reach the engine.
// RULE2: engine runs aes-128 on 128-bit keys and 128-bit blocks.
// RULE3: ecb encrypts and decrypts; cbc encrypts only.
// RULE4: engine runs independently of radio activity.
// RULE5: host loads key, sets mode, writes data, starts, then reads.
// RULE6: key load is mode 0x1 then 16 bytes at 0x84..0x93.
// RULE7: key and data share addresses; mode at write time picks the page.
// RULE8: stored initial key is never altered by a run and reused.
// RULE9: key page reads return last round key of previous run.
// RULE10: mode value 0 selects ecb.
// RULE11: direction bit in control byte picks encrypt or decrypt.
// RULE12: host writes the 16 byte block before starting.
// RULE13: request bit set at 0x83 or 0x94 starts one run.
// RULE14: 0x94 mirrors the control byte.
// RULE15: mode, data and start fit one incrementing burst from 0x83.
// RULE16: writes return previous content, so results stream out.
// RULE17: any access to 0x83 during a run aborts it.
// RULE18: host enables clock output before use in off state.
// RULE19: all accesses refused while sleeping.
// RULE20: sleep or reset clears configuration, data and keys.
// RULE21: mode 0x2 xors input with previous ciphertext.
// RULE22: direction 0 selects encryption.
// RULE23: one run completes in 24 us.
// RULE24: each byte written returns the old content of that location.
// RULE25: request bit clears itself on completion or abort.
// RULE26: reserved mode codes start nothing.
`timescale 1ns/1ps
module cipher_engine (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // power state
    input  wire logic                  sleep,
    // sram access
    input  wire cipher_pkg::sram_req_t acc,
    output logic                       acc_ack,
    output logic [7:0]                 acc_rdata,
    // status
    output logic                       busy
);

    // ==========================================================
    // gf(2^8) and cipher helpers
    function automatic logic [7:0] xt(input logic [7:0] a);
        xt = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a,
                                        input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = xt(x);
        end
        gmul = p;
    endfunction

    // inverse as a^254; costly in area, avoids two 256 entry tables
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h01;
        p = a;
        for (int i = 1; i < 8; i++) begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        ginv = r;
    endfunction

    function automatic logic [7:0] rl(input logic [7:0] a, input int n);
        rl = 8'((a << n) | (a >> (8 - n)));
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] a);
        logic [7:0] b;
        b = ginv(a);
        sbox = b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
    endfunction

    function automatic logic [7:0] isbox(input logic [7:0] a);
        isbox = ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
    endfunction

    // byte i is row i%4, column i/4, msb first
    function automatic logic [127:0] sub_shift(input logic [127:0] s,
                                               input logic inv);
        logic [127:0] o;
        int src;
        o = 128'h0;
        for (int i = 0; i < 16; i++) begin
            src = inv ? ((i + 16 - 4 * (i % 4)) % 16)
                      : ((i + 4 * (i % 4)) % 16);
            o[127-8*i -: 8] = inv ? isbox(s[127-8*src -: 8])
                                  : sbox(s[127-8*src -: 8]);
        end
        sub_shift = o;
    endfunction

    function automatic logic [127:0] mix(input logic [127:0] s,
                                         input logic inv);
        logic [127:0] o;
        logic [7:0] c0, c1, c2, c3;
        logic [7:0] k0, k1, k2, k3;
        o = 128'h0;
        k0 = inv ? 8'h0E : 8'h02;
        k1 = inv ? 8'h0B : 8'h03;
        k2 = inv ? 8'h0D : 8'h01;
        k3 = inv ? 8'h09 : 8'h01;
        for (int c = 0; c < 4; c++) begin
            c0 = s[127-32*c -: 8];
            c1 = s[119-32*c -: 8];
            c2 = s[111-32*c -: 8];
            c3 = s[103-32*c -: 8];
            o[127-32*c -: 8] = gmul(c0, k0) ^ gmul(c1, k1)
                             ^ gmul(c2, k2) ^ gmul(c3, k3);
            o[119-32*c -: 8] = gmul(c0, k3) ^ gmul(c1, k0)
                             ^ gmul(c2, k1) ^ gmul(c3, k2);
            o[111-32*c -: 8] = gmul(c0, k2) ^ gmul(c1, k3)
                             ^ gmul(c2, k0) ^ gmul(c3, k1);
            o[103-32*c -: 8] = gmul(c0, k1) ^ gmul(c1, k2)
                             ^ gmul(c2, k3) ^ gmul(c3, k0);
        end
        mix = o;
    endfunction

    function automatic logic [31:0] subrot(input logic [31:0] w,
                                           input logic [7:0] rc);
        subrot = {sbox(w[23:16]) ^ rc, sbox(w[15:8]),
                  sbox(w[7:0]), sbox(w[31:24])};
    endfunction

    function automatic logic [127:0] key_fwd(input logic [127:0] k,
                                             input logic [7:0] rc);
        logic [31:0] n0, n1, n2, n3;
        n0 = k[127:96] ^ subrot(k[31:0], rc);
        n1 = k[95:64] ^ n0;
        n2 = k[63:32] ^ n1;
        n3 = k[31:0] ^ n2;
        key_fwd = {n0, n1, n2, n3};
    endfunction

    // walks the schedule backwards from a last round key
    function automatic logic [127:0] key_back(input logic [127:0] k,
                                              input logic [7:0] rc);
        logic [31:0] n0, n1, n2, n3;
        n3 = k[31:0] ^ k[63:32];
        n2 = k[63:32] ^ k[95:64];
        n1 = k[95:64] ^ k[127:96];
        n0 = k[127:96] ^ subrot(n3, rc);
        key_back = {n0, n1, n2, n3};
    endfunction

    // ==========================================================
    // reset release
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ==========================================================
    // engine state; no radio input exists, runs overlap frames freely
    cipher_pkg::engine_state_t s_ff; // RULE4
    cipher_pkg::engine_state_t nxt_s;

    logic        in_win;
    logic        blk_hit;
    logic        ctl_hit;
    logic [3:0]  bidx;
    logic [7:0]  ctl_byte;
    logic [7:0]  old_byte;
    logic [127:0] rk_n;
    logic [127:0] st_n;
    logic [2:0]  wmode;

    always_comb begin
        in_win  = acc.addr >= cipher_pkg::ADDR_STATUS
               && acc.addr <= cipher_pkg::ADDR_ALIAS; // RULE1
        blk_hit = acc.addr >= cipher_pkg::ADDR_BLK_LO
               && acc.addr <= cipher_pkg::ADDR_BLK_HI;
        ctl_hit = acc.addr == cipher_pkg::ADDR_CTRL
               || acc.addr == cipher_pkg::ADDR_ALIAS; // RULE14
        bidx    = 4'(acc.addr - cipher_pkg::ADDR_BLK_LO);
        ctl_byte = 8'h00;
        ctl_byte[cipher_pkg::CTRL_REQ_BIT] = s_ff.req; // RULE25
        ctl_byte[cipher_pkg::CTRL_MODE_LSB +: 3] = s_ff.mode;
        ctl_byte[cipher_pkg::CTRL_DIR_BIT] = s_ff.dir;
        wmode   = acc.wdata[cipher_pkg::CTRL_MODE_LSB +: 3];

        // old content is returned on reads and writes alike
        if (ctl_hit) begin
            old_byte = ctl_byte;
        end else if (blk_hit && s_ff.mode == cipher_pkg::MODE_KEY) begin
            old_byte = s_ff.lrk[127-8*bidx -: 8]; // RULE9
        end else if (blk_hit) begin
            old_byte = s_ff.data[127-8*bidx -: 8]; // RULE16 RULE24
        end else if (acc.addr == cipher_pkg::ADDR_STATUS) begin
            old_byte = 8'h00;
            old_byte[cipher_pkg::STATUS_DONE_BIT] = s_ff.done;
        end else begin
            old_byte = 8'h00;
        end

        // one round per clock, the rest of the run is idle padding
        if (s_ff.dec) begin
            rk_n = key_back(s_ff.rk, s_ff.rcon);
            st_n = sub_shift(s_ff.st, 1'b1) ^ rk_n;
            if (s_ff.round != 4'hA) st_n = mix(st_n, 1'b1);
        end else begin
            rk_n = key_fwd(s_ff.rk, s_ff.rcon); // RULE2
            st_n = sub_shift(s_ff.st, 1'b0);
            if (s_ff.round != 4'hA) st_n = mix(st_n, 1'b0);
            st_n = st_n ^ rk_n;
        end

        nxt_s = s_ff;
        nxt_s.ack = 1'b0;

        if (s_ff.busy) begin
            nxt_s.cnt = s_ff.cnt + 12'h001;
            if (s_ff.round != cipher_pkg::ROUND_END) begin
                nxt_s.st    = st_n;
                nxt_s.rk    = rk_n;
                nxt_s.round = s_ff.round + 4'h1;
                nxt_s.rcon  = s_ff.dec
                    ? (s_ff.rcon == 8'h1B ? 8'h80 : {1'b0, s_ff.rcon[7:1]})
                    : xt(s_ff.rcon);
            end else if (s_ff.cnt == cipher_pkg::OP_CYCLES - 12'h001) begin
                nxt_s.busy = 1'b0; // RULE23
                nxt_s.req  = 1'b0; // RULE25
                nxt_s.done = 1'b1;
                nxt_s.data = s_ff.st;
                nxt_s.prev = s_ff.st;
                nxt_s.lrk  = s_ff.rk; // RULE9
            end
        end

        if ((acc.rd || acc.wr) && in_win) begin
            nxt_s.ack   = 1'b1;
            nxt_s.rdata = old_byte;
            if (acc.addr == cipher_pkg::ADDR_CTRL && s_ff.busy) begin
                nxt_s.busy = 1'b0; // RULE17
                nxt_s.req  = 1'b0; // RULE25
            end
            if (acc.wr && ctl_hit) begin
                nxt_s.mode = wmode; // RULE10
                nxt_s.dir  = acc.wdata[cipher_pkg::CTRL_DIR_BIT]; // RULE11
                if (acc.wdata[cipher_pkg::CTRL_REQ_BIT] && !nxt_s.busy
                    && (wmode == cipher_pkg::MODE_ECB
                        || wmode == cipher_pkg::MODE_CBC)) begin // RULE26
                    // RULE13 RULE15 RULE3
                    nxt_s.req   = 1'b1;
                    nxt_s.busy  = 1'b1;
                    // a completion in this very cycle keeps done set
                    nxt_s.done  = nxt_s.done & ~s_ff.done;
                    nxt_s.cnt   = 12'h000;
                    nxt_s.round = cipher_pkg::ROUND_FIRST;
                    nxt_s.rk    = s_ff.ikey; // RULE8
                    nxt_s.dec   = wmode == cipher_pkg::MODE_ECB
                        && acc.wdata[cipher_pkg::CTRL_DIR_BIT]
                           != cipher_pkg::DIR_ENC; // RULE22
                    nxt_s.rcon  = nxt_s.dec ? cipher_pkg::RCON_LAST
                                            : cipher_pkg::RCON_FIRST;
                    nxt_s.st    = nxt_s.data ^ s_ff.ikey; // RULE12
                    if (wmode == cipher_pkg::MODE_CBC)
                        nxt_s.st = nxt_s.st ^ s_ff.prev; // RULE21
                end
            end else if (acc.wr && blk_hit) begin
                if (s_ff.mode == cipher_pkg::MODE_KEY)
                    nxt_s.ikey[127-8*bidx -: 8] = acc.wdata; // RULE6 RULE7
                else
                    nxt_s.data[127-8*bidx -: 8] = acc.wdata; // RULE7
            end
        end

        if (sleep) begin
            nxt_s = '0; // RULE19 RULE20
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_ff <= '0; // RULE20
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign acc_ack   = s_ff.ack;
    assign acc_rdata = s_ff.rdata;
    assign busy      = s_ff.busy;

endmodule

// ==== sim/cipher_checker.sv ====
// checker bound onto the cipher engine ports
// assumes one clock domain with reset_n as its reset
`timescale 1ns/1ps
module cipher_checker (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  reset_n,
    // access and status
    input wire logic                  sleep,
    input wire cipher_pkg::sram_req_t acc,
    input wire logic                  acc_ack,
    input wire logic [7:0]            acc_rdata,
    input wire logic                  busy
);
    // ========
    // helpers
    logic [11:0] cnt_ff;
    logic        take;
    logic        go;
    assign take = (acc.rd | acc.wr) & ~sleep & (acc.addr >= 8'h82)
        & (acc.addr <= 8'h94);
    assign go = acc.wdata[7] & ~acc.wdata[6] & ~acc.wdata[4];
    // run length counted here, a repetition would be far too long
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 12'h000;
        end else begin
            // an abort that restarts at once begins a fresh count
            cnt_ff <= (busy && !(take && acc.addr == 8'h83))
                ? cnt_ff + 12'h001 : 12'h000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_take;
        take;
    endsequence
    sequence s_ctl_wr;
        take && acc.wr && !busy && (acc.addr == 8'h83 || acc.addr == 8'h94);
    endsequence
    // ========
    // assertions
    a_ack_take:
        assert property (s_take |=> acc_ack)
        else $error("access not acked");
    a_sleep_clear:
        assert property (sleep |=> !busy && acc_rdata == 8'h00)
        else $error("sleep left state");
    a_rdata_hold:
        assert property (!take && !sleep |=> $stable(acc_rdata))
        else $error("read data moved");
    a_start_run:
        assert property (s_ctl_wr ##0 go |=> busy)
        else $error("run not started");
    a_reserved_idle:
        assert property (s_ctl_wr ##0 !go |=> !busy)
        else $error("reserved mode ran");
    a_abort_ctrl:
        assert property (busy && take && acc.addr == 8'h83
            && !(acc.wr && go) |=> !busy)
        else $error("run not aborted");
    a_run_holds:
        assert property (busy && cnt_ff < 12'h95F && !sleep
            && !(take && acc.addr == 8'h83) |=> busy)
        else $error("run ended early");
    a_run_end:
        assert property (busy && cnt_ff == 12'h95F |=> !busy)
        else $error("run too long");
endmodule
bind cipher_engine cipher_checker i_chk (.clk(clk), .reset_n(reset_n),
    .sleep(sleep), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
    .busy(busy));

// ==== sim/cipher_host.sv ====
// host model: one byte access per call on the sram port
// assumes strobes are launched on the falling clock edge
`timescale 1ns/1ps
module cipher_host (
    // clock
    input wire logic              clk,
    // access port
    output cipher_pkg::sram_req_t acc,
    input wire logic              acc_ack,
    input wire logic [7:0]        acc_rdata
);
    initial acc = '0;
    task automatic xfer(input logic rd, input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic ok,
                        output logic [7:0] q);
        @(negedge clk);
        acc = {rd, wr, a, d};
        @(negedge clk);
        // released lines show the inverse, not a stale copy
        acc = {2'b00, ~a, ~d};
        ok = acc_ack;
        q = acc_rdata;
    endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench driving the engine through the host model
// assumes checker and host model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
    localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam logic [127:0] LRK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
    logic                  clk;
    logic                  reset_n;
    logic                  sleep;
    cipher_pkg::sram_req_t acc;
    logic                  acc_ack;
    logic [7:0]            acc_rdata;
    logic                  busy;
    logic                  ok;
    logic                  st_m;
    logic [7:0]            q;
    logic [7:0]            ctrl_m;
    logic [7:0]            data_m[16];
    logic [7:0]            lrk_m[16];
    logic [127:0]          rv;
    int                    bad_count;
    int                    compares;
    cipher_engine i_dut (.clk(clk), .reset_n(reset_n), .sleep(sleep),
        .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata), .busy(busy));
    cipher_host i_host (.clk(clk), .acc(acc), .acc_ack(acc_ack),
        .acc_rdata(acc_rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ========
    // reference model of the visible window
    function automatic logic [7:0] view(input logic [7:0] a);
        if (a == 8'h82) return {7'h00, st_m};
        if (a == 8'h83 || a == 8'h94) return ctrl_m;
        if (ctrl_m[6:4] == 3'h1) return lrk_m[a - 8'h84];
        return data_m[a - 8'h84];
    endfunction
    task automatic end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic put(input logic rd, input logic wr,
                       input logic [7:0] a, input logic [7:0] d);
        logic [7:0] e;
        e = view(a);
        i_host.xfer(rd, wr, a, d, ok, q);
        `CHK("ack", 1'b1, ok)
        `CHK("old byte", e, q)
        if (!wr) return;
        if (a == 8'h83 || a == 8'h94) begin
            ctrl_m = {d[7] & ~d[6] & ~d[4], d[6:3], 3'h0};
            if (ctrl_m[7]) st_m = 1'b0;
        end else if (ctrl_m[6:4] != 3'h1) begin
            data_m[a - 8'h84] = d;
        end
    endtask
    task automatic readall;
        for (int i = 0; i < 19; i++) begin
            put(1'b1, 1'b0, 8'(8'h82 + i), 8'h00);
        end
    endtask
    task automatic readkey;
        put(1'b0, 1'b1, 8'h83, 8'h10);
        readall;
    endtask
    // control byte, block, then start: one incrementing burst
    task automatic load(input logic [7:0] c, input logic [127:0] v);
        put(1'b0, 1'b1, 8'h83, c & 8'h7F);
        for (int i = 0; i < 16; i++) begin
            put(1'b0, 1'b1, 8'(8'h84 + i), v[127 - 8 * i -: 8]);
        end
        put(1'b0, 1'b1, 8'h94, c);
    endtask
    task automatic run(input logic [7:0] c, input logic [127:0] v,
                       input logic [127:0] r, input logic [127:0] k);
        load(c, v);
        finish(r, k);
    endtask
    // waits out the run, then reads the window back
    task automatic finish(input logic [127:0] r, input logic [127:0] k);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        `CHK("run cycles", 2400, n)
        if (n == 3000) end_sim;
        ctrl_m[7] = 1'b0;
        st_m = 1'b1;
        for (int i = 0; i < 16; i++) begin
            data_m[i] = r[127 - 8 * i -: 8];
            lrk_m[i] = k[127 - 8 * i -: 8];
        end
        readall;
    endtask
    initial begin
        reset_n = 1'b0;
        sleep = 1'b0;
        bad_count = 0;
        compares = 0;
        st_m = 1'b0;
        ctrl_m = 8'h00;
        data_m = '{default: 8'h00};
        lrk_m = '{default: 8'h00};
        void'($urandom(59));
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        i_host.xfer(1'b1, 1'b0, 8'h95, 8'h00, ok, q);
        `CHK("outside ack", 1'b0, ok)
        `CHK("outside data", 8'h00, q)
        readall;
        load(8'h10, KEY);
        readall;
        run(8'h80, PT, CT, LRK);
        readkey;
        load(8'h00, PT);
        put(1'b0, 1'b1, 8'h83, 8'h80);
        finish(CT, LRK);
        run(8'hA0, PT ^ CT, CT, LRK);
        rv = {$urandom, $urandom, $urandom, $urandom};
        load(8'h80, rv);
        repeat (20) @(negedge clk);
        put(1'b1, 1'b0, 8'h83, 8'h00);
        ctrl_m[7] = 1'b0;
        `CHK("abort busy", 1'b0, busy)
        readall;
        put(1'b0, 1'b1, 8'h94, 8'hB0);
        `CHK("reserved busy", 1'b0, busy)
        readall;
        load(8'h10, LRK);
        run(8'h88, CT, PT, KEY);
        readkey;
        sleep = 1'b1;
        i_host.xfer(1'b1, 1'b0, 8'h84, 8'h00, ok, q);
        `CHK("sleep ack", 1'b0, ok)
        `CHK("sleep data", 8'h00, q)
        sleep = 1'b0;
        st_m = 1'b0;
        ctrl_m = 8'h00;
        data_m = '{default: 8'h00};
        lrk_m = '{default: 8'h00};
        readall;
        readkey;
        end_sim;
    end
endmodule
